// File: clock_bank_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_bank_control_props #(
  parameter int NUM_CLOCKS = 5
) (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  scl,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe_n,
  input wire logic [2:0]            addr_strap,
  input wire logic                  freq_select_high,
  input wire logic                  freq_select_low,
  input wire logic                  spread_pin_n,
  input wire logic                  bank_enable_pin,
  input wire logic                  bank_drive_n,
  input wire logic [2:0]            bank_multiplier,
  input wire logic [1:0]            freq_code,
  input wire logic                  spread_enable,
  input wire logic                  spread_half_width,
  input wire logic                  source_from_input,
  input wire logic                  source_from_pll2,
  input wire logic                  test_mode,
  input wire logic                  test_bank_clk,
  input wire logic                  crystal_copy_gate,
  input wire logic [NUM_CLOCKS-1:0] bank_clock_gate
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_mult_code: assert property (bank_multiplier == {1'b0, freq_code} + 3'd1)
    else $error("multiplier off code");
  a_drive_pin: assert property (bank_drive_n == !bank_enable_pin)
    else $error("tristate not from pin");
  a_spread_src: assert property (spread_enable |->
    !(source_from_input || source_from_pll2))
    else $error("source with spread on");
  a_src_pick: assert property (!$past(reset) && !spread_enable |->
    source_from_input == spread_half_width && source_from_pll2 == !spread_half_width)
    else $error("source pick wrong");
  a_div_high: assert property ($rose(test_bank_clk) |=>
    $stable(test_bank_clk) ##1 $fell(test_bank_clk))
    else $error("divider high phase");
  a_div_low: assert property ($fell(test_bank_clk) |=>
    $stable(test_bank_clk) ##1 $rose(test_bank_clk))
    else $error("divider low phase");
  a_ack_in_low: assert property ($fell(sda_oe_n) |-> !scl)
    else $error("ack outside clock low");
  a_ack_length: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("ack too short");
  a_reset_vals: assert property ($past(reset) |->
    freq_code == 2'h0 && !spread_enable && !test_mode && crystal_copy_gate &&
    (&bank_clock_gate) && sda_oe_n)
    else $error("reset values wrong");
  a_regs_on_bus: assert property (!$past(reset) &&
    $changed({test_mode, crystal_copy_gate, bank_clock_gate}) |-> $past(scl))
    else $error("register moved off bus");

  c_ack: cover property ($fell(sda_oe_n));
  c_test: cover property ($rose(test_mode));
  c_spread: cover property ($rose(spread_enable));
  c_tristate: cover property ($rose(bank_drive_n));
endmodule : clock_bank_control_props

bind clock_bank_control_regs clock_bank_control_props #(.NUM_CLOCKS(NUM_CLOCKS)) u_props (
  .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .freq_select_high(freq_select_high),
  .freq_select_low(freq_select_low), .spread_pin_n(spread_pin_n),
  .bank_enable_pin(bank_enable_pin), .bank_drive_n(bank_drive_n),
  .bank_multiplier(bank_multiplier), .freq_code(freq_code), .spread_enable(spread_enable),
  .spread_half_width(spread_half_width), .source_from_input(source_from_input),
  .source_from_pll2(source_from_pll2), .test_mode(test_mode), .test_bank_clk(test_bank_clk),
  .crystal_copy_gate(crystal_copy_gate), .bank_clock_gate(bank_clock_gate));
`default_nettype wire

// File: clock_bank_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Control byte 0 bit 7: one means normal, zero means test mode.
// - Test mode: bank clocks carry input clock over four, crystal copy unchanged.
// - Byte 0 bit 0 chooses pins (1) or byte 0 bits 3,4,6 (0).
// - Control-source bit powers up as 1, so pins steer frequency.
// - Byte 0 bit 4 is frequency MSB, bit 3 LSB, used under register control.
// - Byte 0 bit 6 turns spread on, only under register control.
// - Byte 0 bit 5: one gives 0.5 percent, zero gives 1.0 percent width.
// - Spread off: bit 5 zero picks second PLL, one picks input clock.
// - Spread sweeps downward only, never above resting frequency.
// - Under pin control, spread is on while the spread pin is low.
// - Spread pin pulled up; undriven means spread disabled.
// - Byte 1 bit 5 gates the crystal copy output; powers up enabled.
// - Byte 2 bits 0..4 gate bank clocks 0..4; all power up enabled.
// - Bank enable pin low three-states the bank, asynchronously.
// - Bank enable pin pulled up; undriven keeps outputs active.
// - Block write only, command zero, ascending bytes, MSB first, stop anywhere.
module clock_bank_control_regs
  import clock_bank_pkg::*;
#(
  parameter int NUM_CLOCKS = clock_bank_pkg::NUM_BANK_CLOCKS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  scl,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic [2:0]            addr_strap,
  input  wire logic                  freq_select_high,
  input  wire logic                  freq_select_low,
  input  wire logic                  spread_pin_n,
  input  wire logic                  bank_enable_pin,
  output logic                       bank_drive_n,
  output logic [2:0]                 bank_multiplier,
  output logic [1:0]                 freq_code,
  output logic                       spread_enable,
  output logic                       spread_half_width,
  output logic                       source_from_input,
  output logic                       source_from_pll2,
  output logic                       test_mode,
  output logic                       test_bank_clk,
  output logic                       crystal_copy_gate,
  output logic [NUM_CLOCKS-1:0]      bank_clock_gate
);

  // ****************************************
  // Types and declarations
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_WAIT,
    ST_ACK_HOLD
  } serial_state_t;

  serial_state_t state_reg;
  logic [7:0]    shift_reg;
  logic [2:0]    bit_cnt_reg;
  logic [2:0]    phase_reg;
  logic [7:0]    data_idx_reg;
  logic          ack_ok_reg;
  logic          ack_drive_reg;
  logic [7:0]    own_addr_reg;
  logic          scl_prev_reg;
  logic          sda_prev_reg;

  logic [7:0]    output_mode_control;
  logic [7:0]    reference_output_gate;
  logic [7:0]    bank_clock_gates;
  logic [1:0]    test_div_reg;

  logic [1:0]    line_sync;
  logic [2:0]    ctrl_sync;
  logic [2:0]    strap_s;
  logic          scl_s;
  logic          sda_s;
  logic          fs_high_s;
  logic          fs_low_s;
  logic          spread_pin_n_s;
  logic          start_cond;
  logic          stop_cond;
  logic          scl_rise;
  logic          scl_fall;
  logic [7:0]    byte_in;
  logic          byte_done;

  // ****************************************
  // Strap to slave address decode
  // ****************************************
  function automatic logic [7:0] strap_address(input logic [2:0] strap);
    case (strap)
      3'd0:    strap_address = SLAVE_ADDR_0;
      3'd1:    strap_address = SLAVE_ADDR_1;
      3'd2:    strap_address = SLAVE_ADDR_2;
      3'd3:    strap_address = SLAVE_ADDR_3;
      3'd4:    strap_address = SLAVE_ADDR_4;
      3'd5:    strap_address = SLAVE_ADDR_5;
      3'd6:    strap_address = SLAVE_ADDR_6;
      default: strap_address = SLAVE_ADDR_7;
    endcase
  endfunction : strap_address

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'b11)
  ) u_line_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  ({scl, sda_in}),
    .pin_out (line_sync)
  );

  // Spread pin resets high, as its pull-up would hold it
  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b001)
  ) u_ctrl_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  ({freq_select_high, freq_select_low, spread_pin_n}),
    .pin_out (ctrl_sync)
  );

  // Straps pulled up, so they read ones until the pins are seen
  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b111)
  ) u_strap_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (addr_strap),
    .pin_out (strap_s)
  );

  assign scl_s          = line_sync[1];
  assign sda_s          = line_sync[0];
  assign fs_high_s      = ctrl_sync[2];
  assign fs_low_s       = ctrl_sync[1];
  assign spread_pin_n_s = ctrl_sync[0];

  // ****************************************
  // Line event detection
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_cond  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign scl_rise   = scl_s && !scl_prev_reg;
  assign scl_fall   = !scl_s && scl_prev_reg;
  assign byte_in    = {shift_reg[6:0], sda_s};
  assign byte_done  = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == LAST_BIT);

  // Address follows the synchronised straps
  always_ff @(posedge ref_clk) begin
    own_addr_reg <= strap_address(strap_s);
  end

  // ****************************************
  // Serial write engine
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 3'd0;
      phase_reg     <= PHASE_ADDRESS;
      data_idx_reg  <= 8'h00;
      ack_ok_reg    <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg     <= ST_RX;
      bit_cnt_reg   <= 3'd0;
      phase_reg     <= PHASE_ADDRESS;
      data_idx_reg  <= 8'h00;
      ack_drive_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg     <= ST_IDLE;
      ack_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          ack_drive_reg <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= ST_ACK_WAIT;
              case (phase_reg)
                PHASE_ADDRESS: ack_ok_reg <= (byte_in == own_addr_reg);
                PHASE_COMMAND: ack_ok_reg <= (byte_in == BLOCK_COMMAND_CODE);
                default:       ack_ok_reg <= 1'b1;
              endcase
            end
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            if (ack_ok_reg) begin
              ack_drive_reg <= 1'b1;
              state_reg     <= ST_ACK_HOLD;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK_HOLD: begin
          if (scl_fall) begin
            ack_drive_reg <= 1'b0;
            bit_cnt_reg   <= 3'd0;
            state_reg     <= ST_RX;
            if (phase_reg == PHASE_DATA) begin
              if (data_idx_reg != 8'hff) begin
                data_idx_reg <= data_idx_reg + 8'h01;
              end
            end else begin
              phase_reg <= phase_reg + 3'd1;
            end
          end
        end
        default: begin
          state_reg     <= ST_IDLE;
          ack_drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = !ack_drive_reg;

  // ****************************************
  // Control registers, written byte by byte
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      output_mode_control   <= OUTPUT_MODE_CONTROL_RST;
      reference_output_gate <= REFERENCE_OUTPUT_GATE_RST;
      bank_clock_gates      <= BANK_CLOCK_GATES_RST;
    end else if (byte_done && (phase_reg == PHASE_DATA)) begin
      // Each complete byte commits on its own; bytes past the map are dropped
      case (data_idx_reg)
        OUTPUT_MODE_CONTROL_IDX:   output_mode_control   <= byte_in;
        REFERENCE_OUTPUT_GATE_IDX: reference_output_gate <= byte_in;
        BANK_CLOCK_GATES_IDX:      bank_clock_gates      <= byte_in;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Test-mode divide by four
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      test_div_reg <= 2'd0;
    end else begin
      test_div_reg <= test_div_reg + 2'd1;
    end
  end

  // ****************************************
  // Frequency and spread selection
  // ****************************************
  logic       pin_source;
  logic [1:0] freq_code_next;
  logic       spread_next;
  logic       width_bit;

  assign pin_source = output_mode_control[PIN_CONTROL_SOURCE_BIT];
  assign width_bit  = output_mode_control[SPREAD_WIDTH_BIT];

  always_comb begin
    if (pin_source) begin
      freq_code_next = {fs_high_s, fs_low_s};
      spread_next    = !spread_pin_n_s;
    end else begin
      freq_code_next = {output_mode_control[FREQ_SELECT_HIGH_BIT],
                        output_mode_control[FREQ_SELECT_LOW_BIT]};
      spread_next    = output_mode_control[SPREAD_ON_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      freq_code         <= 2'b00;
      bank_multiplier   <= 3'd1;
      spread_enable     <= 1'b0;
      spread_half_width <= 1'b1;
      source_from_input <= 1'b0;
      source_from_pll2  <= 1'b0;
    end else begin
      freq_code         <= freq_code_next;
      bank_multiplier   <= {1'b0, freq_code_next} + 3'd1;
      spread_enable     <= spread_next;
      spread_half_width <= width_bit;
      source_from_input <= !spread_next && width_bit;
      source_from_pll2  <= !spread_next && !width_bit;
    end
  end

  // ****************************************
  // Mode and gate outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      test_mode         <= 1'b0;
      test_bank_clk     <= 1'b0;
      crystal_copy_gate <= 1'b1;
      bank_clock_gate   <= '1;
    end else begin
      test_mode         <= !output_mode_control[NORMAL_NOT_TEST_SELECT_BIT];
      test_bank_clk     <= test_div_reg[1];
      crystal_copy_gate <= reference_output_gate[CRYSTAL_COPY_GATE_BIT];
      bank_clock_gate   <= bank_clock_gates[NUM_CLOCKS-1:0];
    end
  end

  // Pin acts directly on the drivers, with no clock in the path
  assign bank_drive_n = !bank_enable_pin;

endmodule : clock_bank_control_regs

`default_nettype wire

// File: clock_bank_pkg.sv
package clock_bank_pkg;

  // ****************************************
  // Register indices (block write order)
  // ****************************************
  localparam logic [7:0] OUTPUT_MODE_CONTROL_IDX   = 8'h00;
  localparam logic [7:0] REFERENCE_OUTPUT_GATE_IDX = 8'h01;
  localparam logic [7:0] BANK_CLOCK_GATES_IDX      = 8'h02;
  localparam int         NUM_REGS                  = 3;

  // ****************************************
  // Power-up values
  // ****************************************
  localparam logic [7:0] OUTPUT_MODE_CONTROL_RST   = 8'ha1;
  localparam logic [7:0] REFERENCE_OUTPUT_GATE_RST = 8'hff;
  localparam logic [7:0] BANK_CLOCK_GATES_RST      = 8'hff;

  // ****************************************
  // Field positions, output_mode_control
  // ****************************************
  localparam int NORMAL_NOT_TEST_SELECT_BIT = 7;
  localparam int SPREAD_ON_BIT              = 6;
  localparam int SPREAD_WIDTH_BIT           = 5;
  localparam int FREQ_SELECT_HIGH_BIT       = 4;
  localparam int FREQ_SELECT_LOW_BIT        = 3;
  localparam int PIN_CONTROL_SOURCE_BIT     = 0;

  // ****************************************
  // Field positions, gate registers
  // ****************************************
  localparam int CRYSTAL_COPY_GATE_BIT = 5;
  localparam int NUM_BANK_CLOCKS       = 5;

  // ****************************************
  // Serial protocol
  // ****************************************
  localparam logic [7:0] BLOCK_COMMAND_CODE = 8'h00;
  localparam logic [2:0] PHASE_ADDRESS      = 3'd0;
  localparam logic [2:0] PHASE_COMMAND      = 3'd1;
  localparam logic [2:0] PHASE_COUNT        = 3'd2;
  localparam logic [2:0] PHASE_DATA         = 3'd3;
  localparam logic [2:0] LAST_BIT           = 3'd7;

  // 8-bit write addresses selected by the address straps
  localparam logic [7:0] SLAVE_ADDR_0 = 8'hde;
  localparam logic [7:0] SLAVE_ADDR_1 = 8'hdc;
  localparam logic [7:0] SLAVE_ADDR_2 = 8'hda;
  localparam logic [7:0] SLAVE_ADDR_3 = 8'hd8;
  localparam logic [7:0] SLAVE_ADDR_4 = 8'hd6;
  localparam logic [7:0] SLAVE_ADDR_5 = 8'hd4;
  localparam logic [7:0] SLAVE_ADDR_6 = 8'hd0;
  localparam logic [7:0] SLAVE_ADDR_7 = 8'hd2;

endpackage : clock_bank_pkg

// File: pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= RESET_VAL;
      pin_out  <= RESET_VAL;
    end else begin
      meta_reg <= pin_in;
      pin_out  <= meta_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// File: smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic       ref_clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_low,
  output logic [7:0]      ack_log
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_log = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : hold

  // Ninth bit releases the line and reads the answer
  task automatic put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      hold(4);
      sda_low = (i > 0) ? !b[i-1] : 1'b0;
      hold(4);
      scl = 1'b1;
      hold(4);
      if (i == 0) ack_log = {ack_log[6:0], !sda_line};
      hold(4);
      scl = 1'b0;
    end
  endtask : put_byte

  task automatic write(input logic [7:0] addr, input logic [7:0] cmd,
                       input logic [23:0] d, input int n);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b0;
    put_byte(addr);
    put_byte(cmd);
    put_byte(n[7:0]);
    for (int k = 0; k < n; k++) put_byte(d[23-8*k -: 8]);
    hold(4);
    sda_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b0;
    hold(8);
  endtask : write
endmodule : smbus_host_model
`default_nettype wire

// File: tb_clock_bank_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_bank_control_regs;
  import clock_bank_pkg::*;
  logic        ref_clk, reset, scl, sda_in, sda_out, sda_oe_n, host_low;
  logic        bank_enable_pin, bank_drive_n, spread_enable, spread_half_width;
  logic        source_from_input, source_from_pll2, test_mode, test_bank_clk;
  logic        crystal_copy_gate;
  logic [2:0]  pins;
  logic [2:0]  strap;
  logic [5:0]  div_seen;
  logic [2:0]  bank_multiplier;
  logic [1:0]  freq_code;
  logic [4:0]  bank_clock_gate;
  logic [7:0]  ack_log;
  logic [9:0]  outs;
  logic [20:0] rows [8];
  int          n_errors, cmp_count;

  // Open-drain data line with pull-up
  assign sda_in = !(host_low || (!sda_oe_n && !sda_out));
  assign outs = {freq_code, bank_multiplier, spread_enable, spread_half_width,
                 source_from_input, source_from_pll2, test_mode};

  clock_bank_control_regs dut (
    .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap(strap), .freq_select_high(pins[2]),
    .freq_select_low(pins[1]), .spread_pin_n(pins[0]), .bank_enable_pin(bank_enable_pin),
    .bank_drive_n(bank_drive_n), .bank_multiplier(bank_multiplier), .freq_code(freq_code),
    .spread_enable(spread_enable), .spread_half_width(spread_half_width),
    .source_from_input(source_from_input), .source_from_pll2(source_from_pll2),
    .test_mode(test_mode), .test_bank_clk(test_bank_clk),
    .crystal_copy_gate(crystal_copy_gate), .bank_clock_gate(bank_clock_gate));

  smbus_host_model host (
    .ref_clk(ref_clk), .sda_line(sda_in), .scl(scl), .sda_low(host_low), .ack_log(ack_log));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (80000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    // Row: mode byte, pins {high, low, spread_n}, expected mode outputs
    rows = '{{8'h80, 3'h6, 10'h022}, {8'h88, 3'h7, 10'h142}, {8'h90, 3'h7, 10'h262},
             {8'hb8, 3'h7, 10'h38c}, {8'hc0, 3'h7, 10'h030}, {8'he0, 3'h7, 10'h038},
             {8'h01, 3'h4, 10'h271}, {8'ha1, 3'h3, 10'h14c}};
    n_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    pins = 3'h1;
    strap = 3'h2;
    bank_enable_pin = 1'b1;
    tick(20);
    reset = 1'b0;
    tick(5);
    foreach (rows[i]) begin
      pins = rows[i][12:10];
      host.write(SLAVE_ADDR_2, BLOCK_COMMAND_CODE, {rows[i][20:13], 16'h0000}, 1);
      tick(6);
      check("acks", ack_log[3:0], 4'hf);
      check("mode", outs, rows[i][9:0]);
    end
    host.write(SLAVE_ADDR_2, BLOCK_COMMAND_CODE, 24'ha1dff5, 3);
    tick(6);
    check("acks", ack_log[5:0], 6'h3f);
    check("ref gate", crystal_copy_gate, 1'b0);
    check("gates", bank_clock_gate, 5'h15);
    host.write(SLAVE_ADDR_3, BLOCK_COMMAND_CODE, 24'hffffff, 3);
    tick(6);
    check("bad addr acks", ack_log[5:0], 6'h00);
    host.write(SLAVE_ADDR_2, 8'h01, 24'hffffff, 3);
    tick(6);
    check("bad cmd acks", ack_log[5:0], 6'h20);
    check("gates kept", {crystal_copy_gate, bank_clock_gate}, 6'h15);
    host.write(SLAVE_ADDR_2, BLOCK_COMMAND_CODE, 24'ha1ff00, 2);
    tick(6);
    check("ref gate on", crystal_copy_gate, 1'b1);
    check("gates short", bank_clock_gate, 5'h15);
    bank_enable_pin = 1'b0;
    #1;
    check("tristate", bank_drive_n, 1'b1);
    tick(2);
    check("tristate held", bank_drive_n, 1'b1);
    bank_enable_pin = 1'b1;
    #1;
    check("driven", bank_drive_n, 1'b0);
    tick(1);
    for (int k = 0; k < 6; k++) begin
      div_seen[k] = test_bank_clk;
      tick(1);
    end
    check("divider", div_seen[3:0] ^ div_seen[5:2], 4'hf);
    reset = 1'b1;
    pins = 3'h7;
    strap = 3'h7;
    tick(20);
    reset = 1'b0;
    tick(5);
    check("reset mode", outs, 10'h38c);
    check("reset gates", {crystal_copy_gate, bank_clock_gate}, 6'h3f);
    check("reset ack", sda_oe_n, 1'b1);
    check("sda value", sda_out, 1'b0);
    host.write(SLAVE_ADDR_7, BLOCK_COMMAND_CODE, 24'h800000, 1);
    tick(6);
    check("strap acks", ack_log[3:0], 4'hf);
    check("strap mode", outs, 10'h022);
    end_sim();
  end
endmodule : tb_clock_bank_control_regs
`default_nettype wire
